// *** rtl/rpr_pkg.sv ***
// Types shared by the reference index remap block.
package rpr_pkg;
	typedef enum logic [1:0] {
		RPR_OP_MINUS,
		RPR_OP_PLUS,
		RPR_OP_LONG,
		RPR_OP_END
	} rpr_op_e;
	typedef enum logic [1:0] {
		RPR_FETCH_ONE,
		RPR_FETCH_RIGHT,
		RPR_FETCH_DOWN,
		RPR_FETCH_FOUR
	} rpr_fetch_e;
endpackage : rpr_pkg

// *** rtl/rpr_regs.svh ***
// Register offsets, field positions and constants of the reference index remap block.
// Operation
// R1 - Non-B indices are default order unless remap fields came in picture, GOB or slice.
// R2 - B pictures take one or two first pictures backward; forward indexes the rest.
// R3 - Remap indicator picks difference or long-term field, and the difference sign.
// R4 - First difference is from current number, later ones from last difference remap.
// R5 - Long-term remaps leave the number prediction unchanged.
// R6 - Long-term remap assigns next index to picture with that long-term index.
// R7 - Pictures not remapped follow all remapped ones in default order.
// R8 - Flag missing picture on number gap or remap naming an absent picture.
// R9 - Optionally conceal by copying closest preceding available picture; the code copies slot 0, the newly stored picture.
// R10 - Concealed picture is inserted only with sliding window buffering.
// R11 - Missing picture found in GOB or slice is concealed as at picture level.
// R12 - Encoder never predicts from pictures or sub-pictures it marked unused.
// R13 - Sub-pictures are equal rectangles, multiples of the minimum unit in 16 samples.
// R14 - Partition grid starts at the picture upper-left corner.
// R15 - Sub-pictures crossing the edge count as full memory in fullness.
// R16 - Sub-pictures numbered from 0 raster order, picture after picture, via map table.
// R17 - Block fetch covers n by m samples, each 8 or 9.
// R18 - Fetch finds sub-picture of upper-left sample by division, plus right/down neighbours.
// R19 - Multi-picture selection only when reference count exceeds one.
// R20 - With four vectors, both chroma blocks use the first vector's reference.
// R21 - Picture numbers are modulo 1024; a step other than one is a gap.
// R22 - A newly stored picture takes default index 0 unless long-term; the code puts long-term pictures at index 0 too.
// R23 - Map entries carry a valid flag; unused entry access is a bitstream error.
`ifndef RPR_REGS_SVH
`define RPR_REGS_SVH
`define RPR_OFF_CTRL     8'h00
`define RPR_OFF_SUBPIC   8'h04
`define RPR_OFF_PICSIZE  8'h08
`define RPR_OFF_STATUS   8'h0c
`define RPR_OFF_MAPIDX   8'h10
`define RPR_OFF_MAPDATA  8'h14
`define RPR_OFF_CAPACITY 8'h18
`define RPR_CTRL_CONCEAL 0
`define RPR_CTRL_SLIDING 1
`define RPR_CTRL_BTWO    2
`define RPR_CTRL_RCNT_LO 4
`define RPR_MAP_VALID    31
`define RPR_ST_MISSING   0
`define RPR_ST_BSERR     1
`define RPR_ST_FULL      2
`define RPR_ST_USED_LO   8
`define RPR_MB_SAMPLES   16
`define RPR_PN_MOD       1024
`endif

// *** rtl/rpr_remap.sv ***
// Reference picture index remap, concealment and sub-picture fetch locator.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "rpr_regs.svh"
module rpr_remap
	import rpr_pkg::*;
#(
	parameter int NREF = 8,
	parameter int KMAP = 64,
	parameter int LTW  = 4,
	parameter int AW   = 8
) (
	// Clock and reset.
	input  wire logic                     clk,
	input  wire logic                     nrst,
	// Register port.
	input  wire logic [AW-1:0]            reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic [31:0]                   reg_rdata,
	// Picture, GOB or slice start and stored pictures.
	input  wire logic                     seg_start,
	input  wire logic [9:0]               seg_pic_number,
	input  wire logic                     seg_is_b,
	input  wire logic                     store_stb,
	input  wire logic [9:0]               store_pic_number,
	input  wire logic                     store_long,
	input  wire logic [LTW-1:0]           store_long_index,
	// Remap operations.
	input  wire logic                     remap_stb,
	input  wire logic [1:0]               remap_op_indicator,
	input  wire logic [9:0]               remap_value,
	// Reference lookup.
	input  wire logic                     ref_stb,
	input  wire logic                     ref_backward,
	input  wire logic                     ref_mv4,
	input  wire logic [3:0][$clog2(NREF)-1:0] ref_param,
	input  wire logic                     backward_sel_bit,
	output logic [$clog2(NREF)-1:0]       ref_slot,
	output logic [$clog2(NREF)-1:0]       ref_chroma_slot,
	output logic                          ref_ok,
	output logic                          ref_done,
	// Concealment copy request.
	output logic                          conceal_stb,
	output logic [$clog2(NREF)-1:0]       conceal_src_slot,
	// Sub-picture fetch.
	input  wire logic                     fetch_stb,
	input  wire logic [$clog2(NREF)-1:0]  fetch_slot,
	input  wire logic [10:0]              fetch_x,
	input  wire logic [10:0]              fetch_y,
	input  wire logic                     fetch_n9,
	input  wire logic                     fetch_m9,
	output logic [3:0][$clog2(KMAP)-1:0]  fetch_area,
	output logic [1:0]                    fetch_case,
	output logic                          fetch_err,
	output logic                          fetch_done
);
	localparam int SW = $clog2(NREF);
	localparam int KW = $clog2(KMAP);

	typedef struct packed {
		logic [NREF-1:0]               vld;
		logic [NREF-1:0]               lng;
		logic [NREF-1:0][9:0]          pn;
		logic [NREF-1:0][LTW-1:0]      lti;
		logic [NREF-1:0][SW-1:0]       rl;
		logic [SW:0]                   rcnt;
		logic [NREF-1:0]               rmask;
		logic                          ractive;
		logic                          is_b;
		logic [9:0]                    pred;
		logic [9:0]                    last_pn;
		logic                          have_pic;
		logic                          conceal_en;
		logic                          sliding;
		logic                          btwo;
		logic [3:0]                    rcount;
		logic [7:0]                    sub_w;
		logic [7:0]                    sub_h;
		logic [7:0]                    pic_w;
		logic [7:0]                    pic_h;
		logic [15:0]                   capacity;
		logic                          missing;
		logic                          bserr;
		logic [KW-1:0]                 map_idx;
		logic [KMAP-1:0]               map_vld;
		logic [KMAP-1:0][KW-1:0]       map;
		logic [31:0]                   rdata;
		logic [SW-1:0]                 ref_slot;
		logic [SW-1:0]                 ref_cslot;
		logic                          ref_ok;
		logic                          ref_done;
		logic                          conceal;
		logic [SW-1:0]                 conceal_src;
		logic [3:0][KW-1:0]            farea;
		logic [1:0]                    fcase;
		logic                          ferr;
		logic                          fdone;
	} rpr_state_s;

	rpr_state_s st_q;
	rpr_state_s st_d;

	// ------------------------------------------------------------------
	// Search helpers
	// ------------------------------------------------------------------

	// Short-term slot holding a picture number; bit SW set when absent.
	function automatic logic [SW:0] find_pn(input rpr_state_s s, input logic [9:0] num);
		logic [SW:0] r;
		r = {1'b1, {SW{1'b0}}};
		for (int i = NREF - 1; i >= 0; i--) begin
			if (s.vld[i] && !s.lng[i] && s.pn[i] == num) begin
				r = {1'b0, SW'(i)};
			end
		end
		return r;
	endfunction : find_pn

	// Long-term slot holding a long-term index; bit SW set when absent.
	function automatic logic [SW:0] find_lt(input rpr_state_s s, input logic [9:0] idx);
		logic [SW:0] r;
		r = {1'b1, {SW{1'b0}}};
		for (int i = NREF - 1; i >= 0; i--) begin
			if (s.vld[i] && s.lng[i] && {{(10 - LTW){1'b0}}, s.lti[i]} == idx) begin
				r = {1'b0, SW'(i)};
			end
		end
		return r;
	endfunction : find_lt

	// Relative index to slot; bit SW set when no picture stands there.
	function automatic logic [SW:0] map_index(input rpr_state_s s, input logic [SW:0] idx);
		logic [SW:0] r;
		logic [SW:0] left;
		r = {1'b1, {SW{1'b0}}};
		left = idx;
		if (s.ractive && idx < s.rcnt) begin
			r = {1'b0, s.rl[idx[SW-1:0]]};
		end else begin
			if (s.ractive) begin
				left = idx - s.rcnt;
			end
			// Untouched pictures follow in default order.
			for (int i = 0; i < NREF; i++) begin
				if (s.vld[i] && !(s.ractive && s.rmask[i])) begin // R7
					if (left == '0 && r[SW]) begin
						r = {1'b0, SW'(i)};
					end
					left = left - 1'b1;
				end
			end
		end
		return r;
	endfunction : map_index

	// ------------------------------------------------------------------
	// Partition geometry
	// ------------------------------------------------------------------

	// Sizes in samples; edge sub-pictures are counted whole by rounding up.
	logic [11:0] sub_w_smp;
	logic [11:0] sub_h_smp;
	logic [7:0]  cols;
	logic [7:0]  rows;
	logic [15:0] per_pic;
	logic [15:0] used;
	logic [11:0] x_end;
	logic [11:0] y_end;
	logic [7:0]  cx;
	logic [7:0]  cy;
	logic [7:0]  cx_end;
	logic [7:0]  cy_end;
	logic [15:0] k_base;
	logic [KW-1:0] kk;
	logic [KW-1:0] k_right;
	logic [KW-1:0] k_down;
	logic [SW:0]   sel_idx;
	logic [SW:0]   sel_c;

	always_comb begin
		sub_w_smp = 12'(st_q.sub_w) * 12'(`RPR_MB_SAMPLES); // R13
		sub_h_smp = 12'(st_q.sub_h) * 12'(`RPR_MB_SAMPLES); // R13
		cols = (st_q.sub_w == '0) ? 8'h01 : 8'((st_q.pic_w + st_q.sub_w - 8'h01) / st_q.sub_w);
		rows = (st_q.sub_h == '0) ? 8'h01 : 8'((st_q.pic_h + st_q.sub_h - 8'h01) / st_q.sub_h);
		per_pic = 16'(cols) * 16'(rows); // R15
		used = 16'($countones(st_q.vld)) * per_pic; // R15
		// Grid origin is the picture corner, so plain division gives the cell.
		x_end = 12'(fetch_x) + (fetch_m9 ? 12'h008 : 12'h007); // R17
		y_end = 12'(fetch_y) + (fetch_n9 ? 12'h008 : 12'h007); // R17
		cx = (sub_w_smp == '0) ? 8'h00 : 8'(12'(fetch_x) / sub_w_smp); // R14 R18
		cy = (sub_h_smp == '0) ? 8'h00 : 8'(12'(fetch_y) / sub_h_smp); // R14 R18
		cx_end = (sub_w_smp == '0) ? 8'h00 : 8'(x_end / sub_w_smp);
		cy_end = (sub_h_smp == '0) ? 8'h00 : 8'(y_end / sub_h_smp);
		k_base = 16'(fetch_slot) * per_pic + 16'(cy) * 16'(cols) + 16'(cx); // R16
		kk = k_base[KW-1:0];
		k_right = kk + 1'b1;
		k_down = KW'(16'(kk) + 16'(cols));
	end

	// Relative index of the luma and chroma lookups.
	always_comb begin
		if (st_q.rcount <= 4'h1) begin
			sel_idx = '0; // R19
			sel_c = '0;
		end else if (st_q.is_b) begin
			if (ref_backward) begin
				sel_idx = (st_q.btwo && backward_sel_bit) ? (SW + 1)'(1) : '0; // R2
			end else begin
				sel_idx = (st_q.btwo ? (SW + 1)'(2) : (SW + 1)'(1)) + {1'b0, ref_param[0]}; // R2
			end
			sel_c = sel_idx;
		end else begin
			sel_idx = {1'b0, ref_param[0]}; // R1
			sel_c = sel_idx; // R20
		end
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------

	// One process owns every state bit; events win over software clears.
	always_comb begin
		logic [SW:0] hit;
		logic [SW:0] ci;
		logic [9:0]  tgt;
		logic        gap;
		logic        ins;
		hit = '0;
		ci = '0;
		tgt = '0;
		gap = 1'b0;
		ins = 1'b0;
		st_d = st_q;
		st_d.ref_done = 1'b0;
		st_d.fdone = 1'b0;
		st_d.conceal = 1'b0;
		st_d.rdata = '0;

		// Register writes.
		if (reg_wr) begin
			case (reg_addr)
				`RPR_OFF_CTRL: begin
					st_d.conceal_en = reg_wdata[`RPR_CTRL_CONCEAL];
					st_d.sliding = reg_wdata[`RPR_CTRL_SLIDING];
					st_d.btwo = reg_wdata[`RPR_CTRL_BTWO];
					st_d.rcount = reg_wdata[`RPR_CTRL_RCNT_LO +: 4];
				end
				`RPR_OFF_SUBPIC: begin
					st_d.sub_w = reg_wdata[7:0];
					st_d.sub_h = reg_wdata[15:8];
				end
				`RPR_OFF_PICSIZE: begin
					st_d.pic_w = reg_wdata[7:0];
					st_d.pic_h = reg_wdata[15:8];
				end
				`RPR_OFF_STATUS: begin
					if (reg_wdata[`RPR_ST_MISSING]) st_d.missing = 1'b0;
					if (reg_wdata[`RPR_ST_BSERR]) st_d.bserr = 1'b0;
				end
				`RPR_OFF_MAPIDX: st_d.map_idx = reg_wdata[KW-1:0];
				`RPR_OFF_MAPDATA: begin
					st_d.map[st_q.map_idx] = reg_wdata[KW-1:0];
					st_d.map_vld[st_q.map_idx] = reg_wdata[`RPR_MAP_VALID]; // R23
				end
				`RPR_OFF_CAPACITY: st_d.capacity = reg_wdata[15:0];
				default: ;
			endcase
		end

		// Register reads, answered in the following cycle.
		if (reg_rd) begin
			case (reg_addr)
				`RPR_OFF_CTRL: st_d.rdata = {24'h0, st_q.rcount, 1'b0, st_q.btwo,
					st_q.sliding, st_q.conceal_en};
				`RPR_OFF_SUBPIC: st_d.rdata = {16'h0, st_q.sub_h, st_q.sub_w};
				`RPR_OFF_PICSIZE: st_d.rdata = {16'h0, st_q.pic_h, st_q.pic_w};
				`RPR_OFF_STATUS: st_d.rdata = {8'h0, used, 5'h0, (used > st_q.capacity),
					st_q.bserr, st_q.missing}; // R15
				`RPR_OFF_MAPIDX: st_d.rdata = 32'(st_q.map_idx);
				`RPR_OFF_MAPDATA: st_d.rdata = {st_q.map_vld[st_q.map_idx],
					(31 - KW)'(0), st_q.map[st_q.map_idx]};
				`RPR_OFF_CAPACITY: st_d.rdata = {16'h0, st_q.capacity};
				default: st_d.rdata = '0;
			endcase
		end

		// A new picture, GOB or slice drops the previous remapping.
		if (seg_start) begin
			st_d.ractive = 1'b0; // R1
			st_d.rcnt = '0;
			st_d.rmask = '0;
			st_d.pred = seg_pic_number; // R4
			st_d.is_b = seg_is_b;
		end else if (remap_stb) begin
			if (remap_op_indicator != 2'(RPR_OP_END)) begin
				st_d.ractive = 1'b1; // R1
			end
			case (rpr_op_e'(remap_op_indicator))
				RPR_OP_MINUS,
				RPR_OP_PLUS: begin
					tgt = (remap_op_indicator == 2'(RPR_OP_PLUS)) ?
						st_q.pred + remap_value : st_q.pred - remap_value; // R3 R21
					hit = find_pn(st_q, tgt);
					st_d.pred = tgt; // R4
				end
				RPR_OP_LONG: begin
					hit = find_lt(st_q, remap_value); // R5 R6
				end
				default: hit = '0;
			endcase
			if (remap_op_indicator != 2'(RPR_OP_END)) begin
				if (hit[SW]) begin
					st_d.missing = 1'b1; // R8 R11
				end else if (st_q.rcnt < (SW + 1)'(NREF)) begin
					st_d.rl[st_q.rcnt[SW-1:0]] = hit[SW-1:0];
					st_d.rmask[hit[SW-1:0]] = 1'b1;
					st_d.rcnt = st_q.rcnt + 1'b1;
				end
			end
		end

		// Storing shifts every picture one index older, or two when a substitute is inserted.
		if (store_stb) begin
			gap = st_q.have_pic && (store_pic_number - st_q.last_pn != 10'h001); // R21
			if (gap) begin
				st_d.missing = 1'b1; // R8
			end
			ins = gap && st_q.conceal_en && st_q.sliding && st_q.vld[0]; // R9 R10
			for (int i = NREF - 1; i > 1; i--) begin
				st_d.vld[i] = ins ? st_q.vld[i-2] : st_q.vld[i-1];
				st_d.lng[i] = ins ? st_q.lng[i-2] : st_q.lng[i-1];
				st_d.pn[i] = ins ? st_q.pn[i-2] : st_q.pn[i-1];
				st_d.lti[i] = ins ? st_q.lti[i-2] : st_q.lti[i-1];
			end
			// The substitute, now at index 1, copies slot 0, which holds the picture just stored.
			st_d.vld[1] = ins ? 1'b1 : st_q.vld[0];
			st_d.lng[1] = ins ? 1'b0 : st_q.lng[0];
			st_d.pn[1] = ins ? store_pic_number - 10'h001 : st_q.pn[0];
			st_d.lti[1] = ins ? '0 : st_q.lti[0];
			st_d.vld[0] = 1'b1; // R22
			st_d.lng[0] = store_long;
			st_d.pn[0] = store_pic_number;
			st_d.lti[0] = store_long_index;
			st_d.conceal = ins; // R9
			st_d.conceal_src = '0;
			st_d.last_pn = store_pic_number;
			st_d.have_pic = 1'b1;
		end

		// Reference lookup.
		if (ref_stb) begin
			hit = map_index(st_q, sel_idx);
			ci = ref_mv4 ? map_index(st_q, sel_c) : hit; // R20
			st_d.ref_slot = hit[SW-1:0];
			st_d.ref_cslot = ci[SW-1:0];
			st_d.ref_ok = !hit[SW];
			st_d.ref_done = 1'b1;
			if (hit[SW]) begin
				st_d.missing = 1'b1; // R8
			end
		end

		// Sub-picture fetch: corners decide which neighbours are needed.
		if (fetch_stb) begin
			st_d.farea[0] = st_q.map[kk];
			st_d.farea[1] = st_q.map[k_right];
			st_d.farea[2] = st_q.map[k_down];
			st_d.farea[3] = st_q.map[k_down + 1'b1];
			st_d.fcase = {cy_end != cy, cx_end != cx}; // R18
			st_d.ferr = !st_q.map_vld[kk] ||
				((cx_end != cx) && !st_q.map_vld[k_right]) ||
				((cy_end != cy) && !st_q.map_vld[k_down]) ||
				((cx_end != cx) && (cy_end != cy) && !st_q.map_vld[k_down + 1'b1]); // R23
			st_d.fdone = 1'b1;
			if (st_d.ferr) begin
				st_d.bserr = 1'b1; // R23
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------

	// Synchronous active-low reset clears all state.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from state flip-flops.
	assign reg_rdata = st_q.rdata;
	assign ref_slot = st_q.ref_slot;
	assign ref_chroma_slot = st_q.ref_cslot;
	assign ref_ok = st_q.ref_ok;
	assign ref_done = st_q.ref_done;
	assign conceal_stb = st_q.conceal;
	assign conceal_src_slot = st_q.conceal_src;
	assign fetch_area = st_q.farea;
	assign fetch_case = st_q.fcase;
	assign fetch_err = st_q.ferr;
	assign fetch_done = st_q.fdone;
endmodule : rpr_remap
`default_nettype wire

// *** tb/rpr_enc.sv ***
// Behavioural model of the bitstream side: segment starts, stored pictures, remaps.
`timescale 1ns/100ps
`default_nettype none
module rpr_enc (
	// Clock.
	input wire logic  clk,
	// Segment start.
	output logic       seg_start,
	output logic [9:0] seg_pic_number,
	output logic       seg_is_b,
	// Stored pictures.
	output logic       store_stb,
	output logic [9:0] store_pic_number,
	output logic       store_long,
	output logic [3:0] store_long_index,
	// Remap operations.
	output logic       remap_stb,
	output logic [1:0] remap_op_indicator,
	output logic [9:0] remap_value
);
	// Idle values at time zero.
	initial begin
		{seg_start, seg_pic_number, seg_is_b, store_stb, store_pic_number} = '0;
		{store_long, store_long_index, remap_stb, remap_op_indicator, remap_value} = '0;
	end
	// ----------------------------------------
	// Commands
	// ----------------------------------------
	// Released number and value fields turn to the inverse so stale data is never mistaken for fresh.
	task seg(input logic [9:0] pn, input logic b);
		@(posedge clk);
		seg_start <= 1'b1;
		seg_pic_number <= pn;
		seg_is_b <= b;
		@(posedge clk);
		seg_start <= 1'b0;
		seg_pic_number <= ~pn;
	endtask : seg
	// Numbers wrap at ten bits; the model never predicts from pictures it dropped.
	task store(input logic [9:0] pn, input logic lg);
		@(posedge clk);
		store_stb <= 1'b1;
		store_pic_number <= pn;
		store_long <= lg;
		@(posedge clk);
		store_stb <= 1'b0;
		store_pic_number <= ~pn;
	endtask : store
	task remap(input logic [1:0] op, input logic [9:0] v);
		@(posedge clk);
		remap_stb <= 1'b1;
		remap_op_indicator <= op;
		remap_value <= v;
		@(posedge clk);
		remap_stb <= 1'b0;
		remap_value <= ~v;
	endtask : remap
endmodule : rpr_enc
`default_nettype wire

// *** tb/rpr_remap_assertions.sv ***
// Port-level assertions for the reference index remap block.
`timescale 1ns/100ps
`default_nettype none
module rpr_remap_checker #(
	parameter int NREF = 8,
	parameter int KMAP = 64
) (
	// Clock, reset and requests.
	input wire logic                    clk,
	input wire logic                    nrst,
	input wire logic                    ref_stb,
	input wire logic                    ref_mv4,
	input wire logic                    store_stb,
	input wire logic                    fetch_stb,
	// Answers.
	input wire logic [$clog2(NREF)-1:0] ref_slot,
	input wire logic [$clog2(NREF)-1:0] ref_chroma_slot,
	input wire logic                    ref_done,
	input wire logic                    conceal_stb,
	input wire logic [$clog2(NREF)-1:0] conceal_src_slot,
	input wire logic [1:0]              fetch_case,
	input wire logic                    fetch_err,
	input wire logic                    fetch_done
);
	// ----------------------------------------
	// Timing and hold relations
	// ----------------------------------------
	// All checks share the one clock, so reset disables them all at once.
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_fetch_req;
		fetch_stb ##1 fetch_done;
	endsequence
	property p_ref_answer;
		ref_stb |=> ref_done;
	endproperty
	property p_ref_pulse;
		ref_done |-> $past(ref_stb);
	endproperty
	property p_fetch_answer;
		fetch_stb |=> fetch_done;
	endproperty
	property p_fetch_pulse;
		fetch_done |-> $past(fetch_stb);
	endproperty
	// The case and error flag must not move in the cycle after they appear unless a new fetch arrives then; a back-to-back fetch may move them.
	property p_fetch_hold;
		s_fetch_req ##0 !fetch_stb |=> $stable(fetch_case) && $stable(fetch_err);
	endproperty
	property p_chroma;
		ref_done && $past(ref_mv4) |-> ref_chroma_slot == ref_slot;
	endproperty
	// The guard on reset keeps a value from before a reset out of the comparison.
	property p_slot_hold;
		$past(nrst) && !$past(ref_stb) |-> $stable(ref_slot);
	endproperty
	property p_conceal_src;
		conceal_stb |-> conceal_src_slot == '0 && $past(store_stb);
	endproperty
	a_ref_answer: assert property (p_ref_answer) else $error("lookup not answered");
	a_ref_pulse: assert property (p_ref_pulse) else $error("stray lookup done");
	a_fetch_answer: assert property (p_fetch_answer) else $error("fetch not answered");
	a_fetch_pulse: assert property (p_fetch_pulse) else $error("stray fetch done");
	a_fetch_hold: assert property (p_fetch_hold) else $error("fetch result moved");
	a_chroma: assert property (p_chroma) else $error("chroma slot differs");
	a_slot_hold: assert property (p_slot_hold) else $error("slot moved unasked");
	a_conceal_src: assert property (p_conceal_src) else $error("bad concealment");
endmodule : rpr_remap_checker
bind rpr_remap rpr_remap_checker #(.NREF(NREF), .KMAP(KMAP)) u_rpr_remap_checker (.clk, .nrst,
	.ref_stb, .ref_mv4, .store_stb, .fetch_stb, .ref_slot, .ref_chroma_slot, .ref_done,
	.conceal_stb, .conceal_src_slot, .fetch_case, .fetch_err, .fetch_done);
`default_nettype wire

// *** tb/rpr_remap_bench.sv ***
// Self-checking testbench of the reference index remap block.
`timescale 1ns/100ps
`default_nettype none
`include "rpr_regs.svh"
module rpr_remap_bench;
	logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic [7:0] reg_addr = 8'h00, lf = 8'h34;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic ref_stb = 1'b0, ref_backward = 1'b0, ref_mv4 = 1'b0, backward_sel_bit = 1'b0;
	logic [3:0][2:0] ref_param = '0;
	logic [2:0] ref_slot, ref_chroma_slot, conceal_src_slot, fetch_slot = 3'h0;
	logic ref_ok, ref_done, conceal_stb, fetch_err, fetch_done;
	logic fetch_stb = 1'b0, fetch_n9 = 1'b0, fetch_m9 = 1'b0;
	logic [10:0] fetch_x = 11'h0, fetch_y = 11'h0;
	logic [3:0][5:0] fetch_area;
	logic [1:0] fetch_case, remap_op_indicator;
	wire seg_start, seg_is_b, store_stb, store_long, remap_stb;
	wire [9:0] seg_pic_number, store_pic_number, remap_value;
	wire [3:0] store_long_index;
	int n_mismatch = 0, n_compared = 0;
	logic [31:0] expq[$];
	rpr_remap u_rpr_remap (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.seg_start, .seg_pic_number, .seg_is_b, .store_stb, .store_pic_number, .store_long,
		.store_long_index, .remap_stb, .remap_op_indicator, .remap_value, .ref_stb,
		.ref_backward, .ref_mv4, .ref_param, .backward_sel_bit, .ref_slot, .ref_chroma_slot,
		.ref_ok, .ref_done, .conceal_stb, .conceal_src_slot, .fetch_stb, .fetch_slot, .fetch_x,
		.fetch_y, .fetch_n9, .fetch_m9, .fetch_area, .fetch_case, .fetch_err, .fetch_done);
	rpr_enc u_rpr_enc (.clk, .seg_start, .seg_pic_number, .seg_is_b, .store_stb,
		.store_pic_number, .store_long, .store_long_index, .remap_stb, .remap_op_indicator,
		.remap_value);
	// Free-running clock.
	always #5 clk = ~clk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : nxt
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task put(input logic [31:0] v);
		expq.push_back(v);
	endtask : put
	// An empty queue compares against unknown, so a surplus result always counts.
	task take(input string nm, input logic [31:0] seen);
		if (expq.size() == 0) check(nm, seen, 'x);
		else check(nm, seen, expq.pop_front());
	endtask : take
	task final_report;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		put(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd
	// Unused parameter lanes carry noise; only the first one may steer the lookup.
	task lk(input logic b, s, m, input logic [2:0] p, e);
		@(posedge clk);
		lf = nxt(lf);
		ref_backward <= b;
		backward_sel_bit <= s;
		ref_mv4 <= m;
		ref_param <= {lf[2:0], lf[5:3], lf[7:5], p};
		ref_stb <= 1'b1;
		put({25'h0, 1'b1, e, e});
		@(posedge clk);
		ref_stb <= 1'b0;
	endtask : lk
	task ft(input logic [2:0] sl, input logic [10:0] x, y, input logic n, m, input logic [26:0] e);
		@(posedge clk);
		{fetch_slot, fetch_x, fetch_y, fetch_n9, fetch_m9} <= {sl, x, y, n, m};
		fetch_stb <= 1'b1;
		put({5'h0, e});
		@(posedge clk);
		fetch_stb <= 1'b0;
	endtask : ft
	// Results are taken off the queue in the cycle they stand.
	always @(posedge clk) begin
		rd_d <= reg_rd;
		if (rd_d) take("rdata", reg_rdata);
		if (ref_done === 1'b1) take("lookup", {25'h0, ref_ok, ref_chroma_slot, ref_slot});
		if (fetch_done === 1'b1) take("fetch", {fetch_err, fetch_case, fetch_area});
		if (conceal_stb === 1'b1) take("conceal", {29'h0, conceal_src_slot});
	end
	// Watchdog sized well beyond the roughly 150 cycles the sequence needs.
	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd(`RPR_OFF_CTRL, 32'h0);
		rd(`RPR_OFF_STATUS, 32'h0);
		lf = nxt(lf);
		wr(8'hfc, {4{lf}});
		rd(8'hfc, 32'h0);
		wr(`RPR_OFF_CTRL, 32'h40);
		rd(`RPR_OFF_CTRL, 32'h40);
		wr(`RPR_OFF_SUBPIC, 32'h202);
		wr(`RPR_OFF_PICSIZE, 32'h303);
		wr(`RPR_OFF_CAPACITY, 32'h8);
		rd(`RPR_OFF_CAPACITY, 32'h8);
		for (int k = 0; k < 8; k++) begin
			wr(`RPR_OFF_MAPIDX, 32'(k));
			wr(`RPR_OFF_MAPDATA, {k != 7, 25'h0, 6'(32 + k)});
		end
		for (int p = 0; p < 3; p++) u_rpr_enc.store(10'(p), 1'b0);
		rd(`RPR_OFF_STATUS, 32'hc04);
		wr(`RPR_OFF_CAPACITY, 32'h40);
		u_rpr_enc.seg(10'd3, 1'b0);
		lk(1'b0, 1'b0, 1'b0, 3'd0, 3'd0);
		lk(1'b0, 1'b0, 1'b0, 3'd2, 3'd2);
		u_rpr_enc.remap(2'd0, 10'd2);
		u_rpr_enc.remap(2'd0, 10'd1);
		lk(1'b0, 1'b0, 1'b0, 3'd0, 3'd1);
		lk(1'b0, 1'b0, 1'b0, 3'd1, 3'd2);
		lk(1'b0, 1'b0, 1'b0, 3'd2, 3'd0);
		u_rpr_enc.seg(10'd3, 1'b0);
		u_rpr_enc.remap(2'd2, 10'd9);
		u_rpr_enc.remap(2'd0, 10'd3);
		lk(1'b0, 1'b0, 1'b0, 3'd0, 3'd2);
		lk(1'b0, 1'b0, 1'b0, 3'd1, 3'd0);
		u_rpr_enc.seg(10'd0, 1'b0);
		u_rpr_enc.remap(2'd1, 10'd1);
		u_rpr_enc.remap(2'd3, 10'd0);
		lk(1'b0, 1'b0, 1'b0, 3'd0, 3'd1);
		rd(`RPR_OFF_STATUS, 32'hc01);
		wr(`RPR_OFF_STATUS, 32'h1);
		rd(`RPR_OFF_STATUS, 32'hc00);
		wr(`RPR_OFF_CTRL, 32'h44);
		u_rpr_enc.seg(10'd4, 1'b1);
		lk(1'b1, 1'b1, 1'b0, 3'd0, 3'd1);
		lk(1'b0, 1'b0, 1'b1, 3'd0, 3'd2);
		wr(`RPR_OFF_CTRL, 32'h40);
		u_rpr_enc.seg(10'd4, 1'b1);
		lk(1'b1, 1'b1, 1'b0, 3'd0, 3'd0);
		lk(1'b0, 1'b0, 1'b0, 3'd0, 3'd1);
		wr(`RPR_OFF_CTRL, 32'h10);
		u_rpr_enc.seg(10'd5, 1'b0);
		lk(1'b0, 1'b0, 1'b0, 3'd2, 3'd0);
		ft(3'd0, 11'd23, 11'd24, 1'b0, 1'b0, {1'b0, 2'd0, 6'd35, 6'd34, 6'd33, 6'd32});
		ft(3'd0, 11'd28, 11'd0, 1'b0, 1'b1, {1'b0, 2'd1, 6'd35, 6'd34, 6'd33, 6'd32});
		ft(3'd0, 11'd0, 11'd28, 1'b1, 1'b0, {1'b0, 2'd2, 6'd35, 6'd34, 6'd33, 6'd32});
		ft(3'd0, 11'd31, 11'd31, 1'b1, 1'b1, {1'b0, 2'd3, 6'd35, 6'd34, 6'd33, 6'd32});
		ft(3'd1, 11'd0, 11'd0, 1'b0, 1'b0, {1'b0, 2'd0, 6'd39, 6'd38, 6'd37, 6'd36});
		ft(3'd1, 11'd40, 11'd40, 1'b0, 1'b0, {1'b1, 2'd0, 6'd0, 6'd0, 6'd0, 6'd39});
		rd(`RPR_OFF_STATUS, 32'hc02);
		wr(`RPR_OFF_CTRL, 32'h43);
		put(32'h0);
		u_rpr_enc.store(10'd4, 1'b0);
		rd(`RPR_OFF_STATUS, 32'h1403);
		repeat (3) @(posedge clk);
		check("queue", 32'(expq.size()), 32'h0);
		final_report();
	end
endmodule : rpr_remap_bench
`default_nettype wire
